// ==== shared/aobs_pkg.sv ====
// Shared constants for the converter output bus and status logic
package aobs_pkg;
   localparam int CLK_PERIOD_NS = 8;
   // Acquisition and conversion times, nanoseconds
   localparam int T_ACQ_NS = 1500;
   localparam int T_CONV_NS = 7000;
   localparam int ACQ_CYC = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_CYC = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 12;
   localparam int RES_W = 12;
   // Nibble field positions on the data bus
   localparam int NIB_LO = 0;
   localparam int NIB_MID = 4;
   localparam int NIB_HI = 8;
   localparam int NIB_W = 4;
   // Code transition points
   localparam logic [11:0] CODE_ZERO = 12'h000;
   localparam logic [11:0] CODE_MID = 12'h800;
   localparam logic [11:0] CODE_FULL = 12'hfff;
   localparam logic [11:0] CODE_FULL_M1 = 12'hffe;
   localparam logic [11:0] OFFSET_FLIP = 12'h800;
   localparam logic [3:0] NIB_ZERO = 4'h0;
   typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} aobs_state_e;
endpackage

// ==== rtl/aobs_quantizer.sv ====
// Maps a sampled code to unipolar straight or bipolar offset binary
`timescale 1ns/10ps
`default_nettype none
module aobs_quantizer (
   input wire logic [11:0] raw_code,
   input wire logic bipolar,
   output logic [11:0] result_code
);
   // Raw code is already quantized with transitions at half-LSB points
   // Bipolar ranges flip the MSB to give offset binary
   assign result_code = bipolar ? (raw_code ^ aobs_pkg::OFFSET_FLIP) : raw_code;
endmodule // aobs_quantizer
`default_nettype wire

// ==== rtl/aobs_top.sv ====
// Conversion status, output bus gating and byte steering of the converter
`timescale 1ns/10ps
`default_nettype none
module aobs_top (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic chip_en,
   input wire logic chip_sel_b,
   input wire logic read_conv,
   input wire logic byte_addr_sel,
   input wire logic data_mode_12,
   input wire logic legacy_mode,
   input wire logic bipolar,
   input wire logic [11:0] sample_code,
   output logic status,
   output logic [11:0] data_out,
   output logic [11:0] data_oe_b
);
   // Two-flop synchronisers for the seven control pins; rst_b is not synchronised
   logic [6:0] pin_s1_r;
   logic [6:0] pin_s2_r;
   logic [6:0] pin_prev_r;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_r <= 7'h00;
         pin_s2_r <= 7'h00;
         pin_prev_r <= 7'h00;
      end else begin
         pin_s1_r <= {bipolar, legacy_mode, data_mode_12, byte_addr_sel, read_conv,
                      chip_sel_b, chip_en};
         pin_s2_r <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
      end
   end

   // Sample code arrives from the analog side on its own timing
   // Two flops keep a code caught mid-change out of the result latch
   logic [aobs_pkg::RES_W-1:0] code_s1_r;
   logic [aobs_pkg::RES_W-1:0] code_s2_r;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         code_s1_r <= aobs_pkg::CODE_ZERO;
         code_s2_r <= aobs_pkg::CODE_ZERO;
      end else begin
         code_s1_r <= sample_code;
         code_s2_r <= code_s1_r;
      end
   end

   wire ce_s = pin_s2_r[0];
   wire cs_b_s = pin_s2_r[1];
   wire rc_s = pin_s2_r[2];
   wire a0_s = pin_s2_r[3];
   wire mode12_s = pin_s2_r[4];
   wire legacy_s = pin_s2_r[5];
   wire bip_s = pin_s2_r[6];
   wire ce_prev = pin_prev_r[0];
   wire cs_b_prev = pin_prev_r[1];
   wire rc_prev = pin_prev_r[2];

   // Start on any qualifying edge with the other inputs active
   wire en_all = ce_s && !cs_b_s;
   wire start_edge = (ce_s && !ce_prev) || (!cs_b_s && cs_b_prev) || (!rc_s && rc_prev);
   wire start_req = en_all && !rc_s && start_edge;

   aobs_pkg::aobs_state_e state_r;
   aobs_pkg::aobs_state_e state_nxt;
   logic [aobs_pkg::CNT_W-1:0] cnt_r;
   logic [aobs_pkg::CNT_W-1:0] cnt_nxt;
   logic short_r;
   logic [11:0] result_r;
   logic [11:0] quant_code;
   wire busy = (state_r != aobs_pkg::ST_IDLE);

   // Starts while busy fall through the idle check and are dropped
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         aobs_pkg::ST_IDLE: begin
            if (start_req) begin
               // Legacy mode acquires after the start; S/H mode already tracked
               state_nxt = legacy_s ? aobs_pkg::ST_ACQ : aobs_pkg::ST_CONV;
               cnt_nxt = legacy_s ? aobs_pkg::CNT_W'(aobs_pkg::ACQ_CYC - 1)
                                  : aobs_pkg::CNT_W'(aobs_pkg::CONV_CYC - 1);
            end
         end
         aobs_pkg::ST_ACQ: begin
            if (cnt_r == '0) begin
               state_nxt = aobs_pkg::ST_CONV;
               cnt_nxt = aobs_pkg::CNT_W'(aobs_pkg::CONV_CYC - 1);
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         aobs_pkg::ST_CONV: begin
            if (cnt_r == '0) begin
               state_nxt = aobs_pkg::ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         default: state_nxt = aobs_pkg::ST_IDLE;
      endcase
   end

   wire conv_done = (state_r == aobs_pkg::ST_CONV) && (cnt_r == '0);

   aobs_quantizer u_quant (
      .raw_code(code_s2_r),
      .bipolar(bip_s),
      .result_code(quant_code)
   );

   // Sequencer, result latch and short-cycle flag
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= aobs_pkg::ST_IDLE;
         cnt_r <= '0;
         short_r <= 1'b0;
         result_r <= aobs_pkg::CODE_ZERO;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         if (start_req && !busy) short_r <= a0_s;
         // 8-bit cycle keeps only the eight MSBs; sample code carries steps
         if (conv_done) result_r <= short_r ? {quant_code[11:4], aobs_pkg::NIB_ZERO}
                                            : quant_code;
      end
   end

   // Read enable: level read, or stand-alone with chip strapped active
   wire rd_en = en_all && rc_s && !busy;
   wire [2:0] nib_en;
   wire [11:0] bus_nxt;
   wire [11:0] oe_b_nxt;
   assign nib_en[0] = rd_en && (mode12_s || a0_s);
   assign nib_en[1] = rd_en;
   assign nib_en[2] = rd_en && (mode12_s || !a0_s);
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_nib
         localparam int B = gi * aobs_pkg::NIB_W;
         wire zero_mid = (gi == 1) && !mode12_s && a0_s;
         assign bus_nxt[B +: aobs_pkg::NIB_W] = zero_mid ? aobs_pkg::NIB_ZERO
            : result_r[B +: aobs_pkg::NIB_W];
         assign oe_b_nxt[B +: aobs_pkg::NIB_W] = {aobs_pkg::NIB_W{!nib_en[gi]}};
      end
   endgenerate

   // Registered pins; one cycle of latency is far below the access time
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         status <= 1'b0;
         data_out <= 12'h000;
         data_oe_b <= 12'hfff;
      end else begin
         status <= busy && !conv_done;
         data_out <= bus_nxt;
         data_oe_b <= oe_b_nxt;
      end
   end

   // Checks beside the logic
   sequence s_conv_end;
      (state_r == aobs_pkg::ST_CONV) && (cnt_r == '0);
   endsequence
   a_status_falls: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_conv_end |=> !status) else $error("status not low after conversion");
   a_busy_hiz: assert property (@(posedge sys_clk) disable iff (!rst_b)
      busy |=> data_oe_b == 12'hfff) else $error("bus driven while busy");
   a_ignore_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state_r == aobs_pkg::ST_CONV && cnt_r != '0) |=> busy)
      else $error("conversion cut short");
   a_lsb_undriven: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!mode12_s && !a0_s) |=> data_oe_b[3:0] == 4'hf) else $error("lsb driven");
   a_mid_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (rd_en && !mode12_s && a0_s) |=> data_out[7:4] == 4'h0 && data_oe_b[7:4] == 4'h0)
      else $error("middle not zero");
   a_top_undriven: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!mode12_s && a0_s) |=> data_oe_b[11:8] == 4'hf) else $error("top driven");
   a_full_word: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (rd_en && mode12_s) |=> data_oe_b == 12'h000 && data_out == $past(result_r))
      else $error("12-bit read wrong");
   a_read_only_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !rc_s |=> data_oe_b == 12'hfff) else $error("bus driven with rc low");
   a_legacy_acq: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (start_req && !busy && legacy_s) |=> state_r == aobs_pkg::ST_ACQ)
      else $error("legacy start skipped acquisition");
   // Accepted start: state moves, then the status flop follows
   sequence s_start_taken;
      start_req && !busy;
   endsequence
   a_status_rises: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_start_taken |-> ##2 status) else $error("status did not rise");
   a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !busy |=> !status) else $error("status high while idle");
   a_short_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (conv_done && short_r) |=> result_r[3:0] == aobs_pkg::NIB_ZERO)
      else $error("short cycle low nibble not zero");
   a_high_byte: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (rd_en && !mode12_s && !a0_s) |=> data_oe_b == 12'h00f)
      else $error("high byte enables wrong");
endmodule // aobs_top
`default_nettype wire

// ==== tb/aobs_host.sv ====
// Host model driving five of the seven converter control inputs
`timescale 1ns/10ps
`default_nettype none
module aobs_host (
   input wire logic sys_clk,
   output logic chip_en,
   output logic chip_sel_b,
   output logic read_conv,
   output logic byte_addr_sel,
   output logic data_mode_12
);
   // Deselected at read level, so no stray start edge
   task automatic idle();
      chip_en = 1'b0;
      chip_sel_b = 1'b1;
      read_conv = 1'b1;
   endtask
   initial begin
      idle();
      byte_addr_sel = 1'b0;
      data_mode_12 = 1'b1;
   end
   // Start by enable edge, held four cycles to outlast the synchronisers
   task automatic start(input logic a0);
      @(posedge sys_clk) #1;
      chip_sel_b = 1'b0;
      read_conv = 1'b0;
      byte_addr_sel = a0;
      chip_en = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 idle();
   endtask
   // Read held six cycles, returns just after an edge
   task automatic rd(input logic m12, input logic a0);
      @(posedge sys_clk) #1;
      chip_sel_b = 1'b0;
      read_conv = 1'b1;
      data_mode_12 = m12;
      byte_addr_sel = a0;
      chip_en = 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask
endmodule // aobs_host
`default_nettype wire

// ==== tb/test_aobs_top.sv ====
// Self-checking bench for the converter output bus and status logic
`timescale 1ns/10ps
`default_nettype none
module test_aobs_top;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic legacy_mode = 1'b0;
   logic bipolar = 1'b0;
   logic [11:0] sample_code = 12'h000;
   wire logic chip_en, chip_sel_b, read_conv, byte_addr_sel, data_mode_12, status;
   wire logic [11:0] data_out, data_oe_b;
   int miscompares = 0;
   int tests_run = 0;
   int seed = 32'h7069c6d3;
   int busy, exp_busy;
   logic a0s;
   logic [11:0] w;
   always #4 sys_clk = ~sys_clk;
   aobs_host i_aobs_host (.sys_clk(sys_clk), .chip_en(chip_en), .chip_sel_b(chip_sel_b),
      .read_conv(read_conv), .byte_addr_sel(byte_addr_sel), .data_mode_12(data_mode_12));
   aobs_top i_aobs_top (.sys_clk(sys_clk), .rst_b(rst_b), .chip_en(chip_en),
      .chip_sel_b(chip_sel_b), .read_conv(read_conv), .byte_addr_sel(byte_addr_sel),
      .data_mode_12(data_mode_12), .legacy_mode(legacy_mode), .bipolar(bipolar),
      .sample_code(sample_code), .status(status), .data_out(data_out), .data_oe_b(data_oe_b));
   task automatic conclude();
      if (miscompares == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   // Only driven lines are compared; undriven ones carry no meaning
   task automatic rdchk(input logic m12, input logic a0);
      logic [11:0] oe;
      oe = m12 ? 12'h000 : (a0 ? 12'hf00 : 12'h00f);
      i_aobs_host.rd(m12, a0);
      chk(data_oe_b, oe, "enables");
      chk(data_out & ~oe, w & ~oe & ((a0 && !m12) ? 12'h00f : 12'hfff), "data");
      i_aobs_host.idle();
      repeat (6) @(posedge sys_clk);
      #1;
      chk(data_oe_b, 12'hfff, "released");
   endtask
   // Watchdog sized well above four conversions plus reads
   initial begin
      #60000;
      miscompares++;
      conclude();
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      for (int i = 0; i < 4; i++) begin
         legacy_mode = i[1];
         bipolar = 1'($random(seed));
         a0s = i[0];
         sample_code = (i == 0) ? 12'hfff : (i == 3) ? 12'h000 : 12'($random(seed));
         w = (sample_code ^ (bipolar ? aobs_pkg::OFFSET_FLIP : 12'h000)) & (a0s ? 12'hff0 : 12'hfff);
         exp_busy = (legacy_mode ? aobs_pkg::ACQ_CYC : 0) + aobs_pkg::CONV_CYC;
         i_aobs_host.start(a0s);
         busy = 0;
         while (status !== 1'b1 && busy < 20) begin
            @(posedge sys_clk);
            busy++;
         end
         #1 chk(data_oe_b, 12'hfff, "busy bus");
         i_aobs_host.start(!a0s);
         busy = 5;
         while (status === 1'b1 && busy < 2000) begin
            @(posedge sys_clk) #1;
            busy++;
         end
         chk(12'(busy >= exp_busy - 3 && busy <= exp_busy + 2), 12'h001, "busy span");
         repeat (20) @(posedge sys_clk);
         chk(12'(status), 12'h000, "restart");
         rdchk(1'b1, 1'b0);
         rdchk(1'b0, 1'b0);
         rdchk(1'b0, 1'b1);
      end
      conclude();
   end
endmodule // test_aobs_top
`default_nettype wire
